// *** core/dsc_pkg.sv ***
// Shared constants and types for the memory-side command front end.
// Assumes the command pins are sampled by a much faster local clock.
package dsc_pkg;
    localparam int ADDR_W = 14;
    localparam int COL_W = 10;
    localparam int BANK_W = 2;
    localparam int NUM_BANKS = 4;
    localparam int DQ_W = 8;
    localparam int AUTO_CLOSE_BIT = 10;
    localparam int CNT_W = 4;
    localparam logic [2:0] POSTED_DELAY_MAX = 3'h5;
    localparam logic [2:0] CAS_LAT_MIN = 3'h3;
    localparam logic [CNT_W-1:0] BL_SHORT = 4'h4;
    localparam logic [CNT_W-1:0] BL_LONG = 4'h8;
    localparam logic [CNT_W-1:0] WR_LEAD = 4'h2;
    localparam logic [2:0] OP_REF = 3'h1;
    localparam logic [2:0] OP_PRE = 3'h2;
    localparam logic [2:0] OP_ACT = 3'h3;
    localparam logic [2:0] OP_WR = 3'h4;
    localparam logic [2:0] OP_RD = 3'h5;

    typedef enum logic [1:0]
    {
        DSC_IDLE = 2'b00,
        DSC_WAIT = 2'b01,
        DSC_READ = 2'b11,
        DSC_WRITE = 2'b10
    } dsc_burst_st_t;

    typedef struct packed
    {
        logic sel_n;
        logic row_n;
        logic col_n;
        logic wr_n;
        logic [BANK_W-1:0] bank_select;
        logic [ADDR_W-1:0] addr;
    } dsc_cmd_t;

    typedef struct packed
    {
        logic ck_t;
        logic ck_c;
        logic gate;
        dsc_cmd_t cmd;
        logic [DQ_W-1:0] dq;
        logic dm;
        logic strobe;
    } dsc_pins_t;

    typedef struct packed
    {
        logic active;
        logic [ADDR_W-1:0] row;
    } dsc_bank_t;

    typedef struct packed
    {
        logic is_wr;
        logic auto_close;
        logic bl8;
        logic intl;
        logic [BANK_W-1:0] bank;
        logic [COL_W-1:0] col;
    } dsc_burst_t;
endpackage : dsc_pkg

// *** core/dsc_ddr2_cmd.sv ***
// Memory-side command decoder, bank tracker and burst engine with a small data store.
// Assumes ref_clk is well above the link clock; all pins are synchronised first.
// Notes on behaviour
// - Commands and address are taken where the true clock rises and complement falls.
// - Read data beats leave on both clock crossings, two per period.
// - Data on the 8-bit bus is timed by the strobe; we drive it on reads.
// - Bursts are 4 or 8 beats from the column, sequential or interleaved order.
// - Row comes with activate, column with read or write, on shared pins.
// - Four independent banks, each keeping its own open row.
// - Auto close precharges the bank by itself at the end of the burst.
// - Posted column commands add a delay of 0 to 5 cycles.
// - Write latency is one cycle less than read latency.
// - Clock gate sampled low freezes the device from the next cycle.
// - Gate low with all banks idle enters power down or self refresh.
// - Commands are ignored on edges where select is sampled high.
// - Row strobe low, column high: write high activates, low precharges.
// - Row strobe high, column low: write high reads, low writes.
// - Column on A0-A9, bit 10 asks auto close; rows use all bits.
`timescale 1ns/10ps
module dsc_ddr2_cmd
#(
    parameter int COL_BITS = 4
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic diff_timing_true,
    input wire logic diff_timing_complement,
    input wire logic clk_gate,
    input wire logic sel_n,
    input wire logic row_strobe_n,
    input wire logic col_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [dsc_pkg::BANK_W-1:0] bank_select,
    input wire logic [dsc_pkg::ADDR_W-1:0] addr,
    input wire logic [dsc_pkg::DQ_W-1:0] dq_in,
    input wire logic dm_in,
    input wire logic strobe_in,
    input wire logic burst_len8,
    input wire logic burst_interleave,
    input wire logic [2:0] posted_delay,
    input wire logic [2:0] cas_latency,
    output logic [dsc_pkg::DQ_W-1:0] dq_out,
    output logic dq_oe,
    output logic strobe_out,
    output logic strobe_n_out,
    output logic strobe_oe,
    output logic [dsc_pkg::NUM_BANKS-1:0] bank_active,
    output logic burst_busy,
    output logic power_down,
    output logic self_refresh
);
    import dsc_pkg::*;

    localparam int MEM_AW = BANK_W + COL_BITS;
    localparam int MEM_DEPTH = NUM_BANKS << COL_BITS;

    dsc_pins_t pins;
    dsc_pins_t s1_ff;
    dsc_pins_t s2_ff;
    logic ck_prev_ff;
    logic str_prev_ff;

    dsc_bank_t bank_ff [NUM_BANKS];
    dsc_bank_t nxt_bank_ff [NUM_BANKS];
    dsc_burst_st_t st_ff;
    dsc_burst_st_t nxt_st_ff;
    dsc_burst_t acc_ff;
    dsc_burst_t nxt_acc_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt_ff;
    logic [CNT_W-1:0] beat_ff;
    logic [CNT_W-1:0] nxt_beat_ff;
    logic run_ff;
    logic nxt_run_ff;
    logic pd_ff;
    logic nxt_pd_ff;
    logic sr_ff;
    logic nxt_sr_ff;
    logic busy_ff;
    logic nxt_busy_ff;
    logic [DQ_W-1:0] dq_out_ff;
    logic [DQ_W-1:0] nxt_dq_out_ff;
    logic dq_oe_ff;
    logic nxt_dq_oe_ff;
    logic str_ff;
    logic nxt_str_ff;
    logic str_n_ff;
    logic nxt_str_n_ff;
    logic str_oe_ff;
    logic nxt_str_oe_ff;

    logic [DQ_W-1:0] mem [MEM_DEPTH];
    logic mem_we;
    logic [MEM_AW-1:0] mem_idx;

    logic rise;
    logic fall;
    logic rise_t;
    logic edge_t;
    logic str_edge;
    logic [NUM_BANKS-1:0] idle_vec;
    logic all_idle;
    logic [2:0] op;
    logic [CNT_W-1:0] bl_n;
    logic [CNT_W-1:0] rl;
    logic [COL_W-1:0] cur_col;

    function automatic logic [COL_W-1:0] beat_col(input logic [COL_W-1:0] s,
                                                  input logic [2:0] i,
                                                  input logic bl8,
                                                  input logic intl);
        logic [COL_W-1:0] c;
        c = s;
        if (bl8)
            c[2:0] = intl ? (s[2:0] ^ i) : 3'(s[2:0] + i);
        else
            c[1:0] = intl ? (s[1:0] ^ i[1:0]) : 2'(s[1:0] + i[1:0]);
        return c;
    endfunction : beat_col

    assign pins = '{ck_t: diff_timing_true, ck_c: diff_timing_complement, gate: clk_gate,
                    cmd: '{sel_n: sel_n, row_n: row_strobe_n, col_n: col_strobe_n,
                           wr_n: write_strobe_n, bank_select: bank_select, addr: addr},
                    dq: dq_in, dm: dm_in, strobe: strobe_in};

    // Pins and link clock share one two-stage path so their skew stays matched
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            ck_prev_ff <= 1'b0;
            str_prev_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            s1_ff <= pins;
            s2_ff <= s1_ff;
            ck_prev_ff <= s2_ff.ck_t;
            str_prev_ff <= s2_ff.strobe;
        end
    end

    assign rise = s2_ff.ck_t & ~s2_ff.ck_c & ~ck_prev_ff;
    assign fall = ~s2_ff.ck_t & s2_ff.ck_c & ck_prev_ff;
    assign rise_t = rise & run_ff;
    assign edge_t = (rise | fall) & run_ff;
    assign str_edge = (s2_ff.strobe ^ str_prev_ff) & run_ff;
    assign op = {s2_ff.cmd.row_n, s2_ff.cmd.col_n, s2_ff.cmd.wr_n};
    assign bl_n = acc_ff.bl8 ? BL_LONG : BL_SHORT;
    assign all_idle = &idle_vec;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_BANKS; gi++)
        begin : g_bank
            assign idle_vec[gi] = ~bank_ff[gi].active;
            assign bank_active[gi] = bank_ff[gi].active;
        end
    endgenerate

    always_comb
    begin
        logic launch;
        logic close_req;
        logic [2:0] al;
        logic [2:0] cl;
        launch = 1'b0;
        close_req = 1'b0;
        // Out-of-range settings clamp instead of producing a zero latency
        al = (posted_delay > POSTED_DELAY_MAX) ? POSTED_DELAY_MAX : posted_delay;
        cl = (cas_latency < CAS_LAT_MIN) ? CAS_LAT_MIN : cas_latency;
        rl = CNT_W'({1'b0, al}) + CNT_W'({1'b0, cl});
        nxt_bank_ff = bank_ff;
        nxt_st_ff = st_ff;
        nxt_acc_ff = acc_ff;
        nxt_cnt_ff = cnt_ff;
        nxt_beat_ff = beat_ff;
        nxt_run_ff = run_ff;
        nxt_pd_ff = pd_ff;
        nxt_sr_ff = sr_ff;
        nxt_dq_out_ff = dq_out_ff;
        nxt_dq_oe_ff = dq_oe_ff;
        nxt_str_ff = str_ff;
        nxt_str_oe_ff = str_oe_ff;
        cur_col = beat_col(acc_ff.col, beat_ff[2:0], acc_ff.bl8, acc_ff.intl);
        mem_idx = {acc_ff.bank, cur_col[COL_BITS-1:0]};
        mem_we = 1'b0;

        if (rise)
            nxt_run_ff = s2_ff.gate;

        if (rise && run_ff && !s2_ff.gate && all_idle && st_ff == DSC_IDLE)
        begin
            nxt_pd_ff = 1'b1;
            nxt_sr_ff = !s2_ff.cmd.sel_n && op == OP_REF;
        end
        else if (rise && s2_ff.gate)
        begin
            nxt_pd_ff = 1'b0;
            nxt_sr_ff = 1'b0;
        end

        unique case (st_ff)
            DSC_IDLE:
            begin
            end
            DSC_WAIT:
            begin
                if (rise_t)
                begin
                    if (cnt_ff == 4'h1)
                    begin
                        if (acc_ff.is_wr)
                            nxt_st_ff = DSC_WRITE;
                        else
                        begin
                            nxt_st_ff = DSC_READ;
                            launch = 1'b1;
                        end
                    end
                    else
                        nxt_cnt_ff = cnt_ff - 4'h1;
                end
            end
            DSC_READ:
            begin
                if (edge_t)
                begin
                    if (beat_ff == bl_n)
                    begin
                        nxt_st_ff = DSC_IDLE;
                        nxt_dq_oe_ff = 1'b0;
                        nxt_str_oe_ff = 1'b0;
                        close_req = acc_ff.auto_close;
                    end
                    else
                        launch = 1'b1;
                end
            end
            DSC_WRITE:
            begin
                if (str_edge)
                begin
                    mem_we = ~s2_ff.dm;
                    nxt_beat_ff = beat_ff + 4'h1;
                    if (beat_ff == bl_n - 4'h1)
                    begin
                        nxt_st_ff = DSC_IDLE;
                        close_req = acc_ff.auto_close;
                    end
                end
            end
        endcase

        if (launch)
        begin
            nxt_dq_out_ff = mem[mem_idx];
            nxt_dq_oe_ff = 1'b1;
            nxt_str_ff = rise;
            nxt_str_oe_ff = 1'b1;
            nxt_beat_ff = beat_ff + 4'h1;
        end

        if (close_req)
            nxt_bank_ff[acc_ff.bank].active = 1'b0;

        if (rise_t && !s2_ff.cmd.sel_n)
        begin
            unique case (op)
                OP_ACT:
                begin
                    nxt_bank_ff[s2_ff.cmd.bank_select].active = 1'b1;
                    nxt_bank_ff[s2_ff.cmd.bank_select].row = s2_ff.cmd.addr;
                end
                OP_PRE:
                begin
                    // Bit 10 high closes every bank at once
                    for (int b = 0; b < NUM_BANKS; b++)
                        if (s2_ff.cmd.addr[AUTO_CLOSE_BIT] || b == int'(s2_ff.cmd.bank_select))
                            nxt_bank_ff[b].active = 1'b0;
                end
                OP_RD, OP_WR:
                begin
                    // Access to an idle bank, or during a burst, is dropped
                    if (bank_ff[s2_ff.cmd.bank_select].active && st_ff == DSC_IDLE)
                    begin
                        nxt_st_ff = DSC_WAIT;
                        nxt_acc_ff.is_wr = (op == OP_WR);
                        nxt_acc_ff.auto_close = s2_ff.cmd.addr[AUTO_CLOSE_BIT];
                        nxt_acc_ff.bl8 = burst_len8;
                        nxt_acc_ff.intl = burst_interleave;
                        nxt_acc_ff.bank = s2_ff.cmd.bank_select;
                        nxt_acc_ff.col = s2_ff.cmd.addr[COL_W-1:0];
                        // Write window opens one clock early to catch the strobe preamble
                        nxt_cnt_ff = (op == OP_WR) ? rl - WR_LEAD : rl;
                        nxt_beat_ff = 4'h0;
                    end
                end
                default:
                begin
                end
            endcase
        end
        nxt_busy_ff = nxt_st_ff != DSC_IDLE;
        // Own flop for the complement keeps both strobe pins registered
        nxt_str_n_ff = ~nxt_str_ff;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int b = 0; b < NUM_BANKS; b++)
                bank_ff[b] <= '0;
            st_ff <= DSC_IDLE;
            acc_ff <= '0;
            cnt_ff <= '0;
            beat_ff <= '0;
            run_ff <= 1'b0;
            pd_ff <= 1'b0;
            sr_ff <= 1'b0;
            busy_ff <= 1'b0;
            dq_out_ff <= '0;
            dq_oe_ff <= 1'b0;
            str_ff <= 1'b0;
            str_n_ff <= 1'b1;
            str_oe_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            bank_ff <= nxt_bank_ff;
            st_ff <= nxt_st_ff;
            acc_ff <= nxt_acc_ff;
            cnt_ff <= nxt_cnt_ff;
            beat_ff <= nxt_beat_ff;
            run_ff <= nxt_run_ff;
            pd_ff <= nxt_pd_ff;
            sr_ff <= nxt_sr_ff;
            busy_ff <= nxt_busy_ff;
            dq_out_ff <= nxt_dq_out_ff;
            dq_oe_ff <= nxt_dq_oe_ff;
            str_ff <= nxt_str_ff;
            str_n_ff <= nxt_str_n_ff;
            str_oe_ff <= nxt_str_oe_ff;
        end
    end

    // Only the low column bits are stored, so the array aliases across columns
    always_ff @(posedge ref_clk)
    begin
        if (clk_en && mem_we)
            mem[mem_idx] <= s2_ff.dq;
    end

    assign dq_out = dq_out_ff;
    assign dq_oe = dq_oe_ff;
    assign strobe_out = str_ff;
    assign strobe_n_out = str_n_ff;
    assign strobe_oe = str_oe_ff;
    assign burst_busy = busy_ff;
    assign power_down = pd_ff;
    assign self_refresh = sr_ff;
endmodule : dsc_ddr2_cmd

// *** verif/dsc_ddr2_cmd_props.sv ***
// Checker for the command front end: strobe, burst and low power relations.
// Sees only the ports of dsc_ddr2_cmd; attached by the bind at the foot.
`timescale 1ns/10ps
module dsc_ddr2_cmd_chk
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic dq_oe,
    input wire logic strobe_out,
    input wire logic strobe_n_out,
    input wire logic strobe_oe,
    input wire logic [dsc_pkg::NUM_BANKS-1:0] bank_active,
    input wire logic burst_busy,
    input wire logic power_down,
    input wire logic self_refresh
);
    import dsc_pkg::*;
    logic oe_ff;
    logic st_ff;
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic beat;
    assign beat = dq_oe && (!oe_ff || strobe_out != st_ff);
    always_comb
    begin
        nxt_cnt = dq_oe ? cnt_ff + {3'h0, beat} : 4'h0;
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            oe_ff <= 1'b0;
            st_ff <= 1'b0;
            cnt_ff <= 4'h0;
        end
        else
        begin
            oe_ff <= dq_oe;
            st_ff <= strobe_out;
            cnt_ff <= nxt_cnt;
        end
    end
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    strobe_pair_a: assert property (strobe_n_out == !strobe_out)
        else $error("read strobe pair not complementary");
    oe_pair_a: assert property (dq_oe == strobe_oe)
        else $error("data and strobe enables differ");
    oe_busy_a: assert property (dq_oe |-> burst_busy)
        else $error("data driven outside a burst");
    first_beat_a: assert property ($rose(dq_oe) |-> strobe_out)
        else $error("first read beat without strobe high");
    beat_gap_a: assert property (beat |=> $stable(strobe_out) [*3])
        else $error("read beats closer than half a link period");
    burst_len_a: assert property (!dq_oe && oe_ff |-> cnt_ff == BL_SHORT || cnt_ff == BL_LONG)
        else $error("read burst length not 4 or 8");
    idle_power_a: assert property (power_down |-> bank_active == 4'h0 && !burst_busy)
        else $error("low power with bank open or burst running");
    self_ref_a: assert property (self_refresh |-> power_down)
        else $error("self refresh flag without power down");
    freeze_bank_a: assert property (power_down && $past(power_down) |-> $stable(bank_active))
        else $error("bank state moved while clock gated");
    property burst_len8_seen;
        !dq_oe && oe_ff && cnt_ff == BL_LONG;
    endproperty
    burst8_c: cover property (burst_len8_seen);
    power_c: cover property ($rose(power_down));
    selfref_c: cover property ($rose(self_refresh));
endmodule : dsc_ddr2_cmd_chk
bind dsc_ddr2_cmd dsc_ddr2_cmd_chk chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .dq_oe(dq_oe),
    .strobe_out(strobe_out), .strobe_n_out(strobe_n_out), .strobe_oe(strobe_oe),
    .bank_active(bank_active), .burst_busy(burst_busy), .power_down(power_down),
    .self_refresh(self_refresh));

// *** verif/dsc_ctl_model.sv ***
// Memory controller model: free running link clock, commands, gate and write beats.
// Pins change just after a ref_clk edge; released address lines show the inverse.
`timescale 1ns/10ps
module dsc_ctl_model
(
    input wire logic ref_clk,
    output logic lk_t,
    output logic lk_c,
    output logic gate,
    output dsc_pkg::dsc_cmd_t cmd,
    output logic [dsc_pkg::DQ_W-1:0] dq,
    output logic dm,
    output logic dqs
);
    import dsc_pkg::*;
    initial
    begin
        cmd = '{1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 14'h0};
        gate = 1'b1;
        dq = 8'h0;
        dm = 1'b0;
        dqs = 1'b0;
        lk_t = 1'b0;
        #13;
        forever #160 lk_t = ~lk_t;
    end
    assign lk_c = ~lk_t;
    task automatic issue(input logic s, input logic g, input logic [2:0] op,
        input logic [1:0] b, input logic [13:0] a);
        @(negedge lk_t);
        @(posedge ref_clk);
        #2;
        cmd = '{s, op[2], op[1], op[0], b, a};
        gate = g;
        @(negedge lk_t);
        @(posedge ref_clk);
        #2;
        cmd.sel_n = 1'b1;
        cmd.addr = ~a;
    endtask : issue
    task automatic wr_beats(input int rl, input int n, input logic [63:0] d,
        input logic [7:0] m);
        int i;
        repeat (rl - 1) @(posedge lk_t);
        for (i = 0; i < n; i++)
        begin
            @(posedge ref_clk);
            #2;
            dq = d[8*i +: 8];
            dm = m[i];
            repeat (2) @(posedge ref_clk);
            #2;
            dqs = ~dqs;
            @(lk_t);
        end
        @(posedge ref_clk);
        #2;
        dq = ~dq;
    endtask : wr_beats
endmodule : dsc_ctl_model

// *** verif/dsc_ddr2_cmd_tb.sv ***
// Self-checking bench for dsc_ddr2_cmd: banks, bursts, latency and low power.
// Pins come from dsc_ctl_model; expected beats wait in a queue for the watcher.
`timescale 1ns/10ps
module dsc_ddr2_cmd_tb;
    import dsc_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic bl8 = 1'b0;
    logic intl = 1'b0;
    logic [2:0] al = 3'h0;
    logic [2:0] cl = 3'h5;
    logic lk_t, lk_c, gate, dm, dqs, oe_q, st_q;
    logic dq_oe, strobe_out, strobe_oe, burst_busy, power_down, self_refresh;
    logic [7:0] dq, dq_out;
    logic [3:0] bank_active, bk;
    dsc_cmd_t cmd;
    logic [7:0] mem [4][16];
    logic [7:0] exp_q [$];
    logic [31:0] seed = 32'hf600;
    logic [31:0] r;
    int fail_count = 0;
    int compares = 0;
    int a;
    always #20 ref_clk = ~ref_clk;
    dsc_ctl_model m_u (.ref_clk(ref_clk), .lk_t(lk_t), .lk_c(lk_c), .gate(gate),
        .cmd(cmd), .dq(dq), .dm(dm), .dqs(dqs));
    dsc_ddr2_cmd dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
        .diff_timing_true(lk_t), .diff_timing_complement(lk_c), .clk_gate(gate),
        .sel_n(cmd.sel_n), .row_strobe_n(cmd.row_n), .col_strobe_n(cmd.col_n),
        .write_strobe_n(cmd.wr_n), .bank_select(cmd.bank_select), .addr(cmd.addr),
        .dq_in(dq), .dm_in(dm), .strobe_in(dqs), .burst_len8(bl8),
        .burst_interleave(intl), .posted_delay(al), .cas_latency(cl), .dq_out(dq_out),
        .dq_oe(dq_oe), .strobe_out(strobe_out), .strobe_n_out(), .strobe_oe(strobe_oe),
        .bank_active(bank_active), .burst_busy(burst_busy), .power_down(power_down),
        .self_refresh(self_refresh));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done
    function automatic logic [31:0] nxt_rand();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : nxt_rand
    // Column of beat i inside the aligned block of the burst
    function automatic logic [3:0] col_at(input logic [3:0] c, input int i);
        logic [3:0] w;
        w = bl8 ? 4'h7 : 4'h3;
        return (c & ~w) | ((intl ? (c ^ i[3:0]) : (c + i[3:0])) & w);
    endfunction : col_at
    task automatic late();
        repeat (4) @(negedge ref_clk);
    endtask : late
    // Bounded wait on dq_oe (k=1) or burst_busy (k=0)
    task automatic wait_st(input int k, input logic v, input int lim);
        int n;
        n = 0;
        while ((k == 1 ? dq_oe : burst_busy) !== v && n < lim)
        begin
            @(negedge ref_clk);
            n++;
        end
        if ((k == 1 ? dq_oe : burst_busy) !== v)
        begin
            fail_count++;
            test_done();
        end
    endtask : wait_st
    task automatic wr(input logic [1:0] b, input logic [3:0] c, input logic [7:0] m,
        input int rl);
        logic [63:0] d;
        int i;
        d = {nxt_rand(), nxt_rand()};
        for (i = 0; i < (bl8 ? 8 : 4); i++)
            if (!m[i])
                mem[b][col_at(c, i)] = d[8*i +: 8];
        m_u.issue(1'b0, 1'b1, OP_WR, b, {10'h0, c});
        m_u.wr_beats(rl, bl8 ? 8 : 4, d, m);
        wait_st(0, 1'b0, 20);
    endtask : wr
    task automatic rd(input logic [1:0] b, input logic [3:0] c, input logic ac, input int rl);
        int i;
        for (i = 0; i < (bl8 ? 8 : 4); i++)
            exp_q.push_back(mem[b][col_at(c, i)]);
        m_u.issue(1'b0, 1'b1, OP_RD, b, {3'h0, ac, 6'h0, c});
        repeat (rl - 1) @(posedge lk_t);
        repeat (6) @(negedge ref_clk);
        chk({7'h0, dq_oe}, 8'h0);
        @(posedge lk_t);
        wait_st(1, 1'b1, 7);
        wait_st(0, 1'b0, 60);
    endtask : rd
    // Each new read beat takes the oldest expected byte
    always @(negedge ref_clk)
    begin
        if (dq_oe === 1'b1 && (oe_q !== 1'b1 || strobe_out !== st_q))
            chk(dq_out, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
        oe_q = dq_oe;
        st_q = strobe_out;
    end
    initial
    begin
        bk = 4'h0;
        repeat (6) @(posedge ref_clk);
        #2;
        rst_n = 1'b1;
        @(negedge ref_clk);
        chk({bank_active, dq_oe, burst_busy, power_down, self_refresh}, 8'h0);
        // A link rise must see the gate high first, or the select test below proves nothing
        repeat (2) @(posedge lk_t);
        m_u.issue(1'b1, 1'b1, OP_ACT, 2'h2, 14'h0);
        late();
        chk({4'h0, bank_active}, 8'h0);
        m_u.issue(1'b0, 1'b1, OP_WR, 2'h3, 14'h0);
        late();
        chk({7'h0, burst_busy}, 8'h0);
        for (a = 0; a < 4; a++)
        begin
            r = nxt_rand();
            m_u.issue(1'b0, 1'b1, OP_ACT, a[1:0], r[13:0]);
            late();
            bk[a] = 1'b1;
            chk({4'h0, bank_active}, {4'h0, bk});
        end
        // Gate low with banks open: frozen, no power down, the precharge is not seen
        m_u.issue(1'b1, 1'b0, OP_ACT, 2'h0, 14'h0);
        m_u.issue(1'b0, 1'b0, OP_PRE, 2'h0, 14'h0400);
        late();
        chk({bank_active, 3'h0, power_down}, 8'hf0);
        m_u.issue(1'b1, 1'b1, OP_ACT, 2'h0, 14'h0);
        for (a = 0; a < 6; a++)
        begin
            @(posedge ref_clk);
            #2;
            al = a[2:0];
            bl8 = a[0];
            intl = a[1];
            r = nxt_rand();
            wr(a[1:0], r[3:0], 8'h0, a + 5);
            wr(a[1:0], r[3:0], 8'h05, a + 5);
            rd(a[1:0], r[3:0], a == 5, a + 5);
        end
        late();
        chk({4'h0, bank_active}, 8'h0d);
        m_u.issue(1'b0, 1'b1, OP_PRE, 2'h0, 14'h0);
        late();
        chk({4'h0, bank_active}, 8'h0c);
        m_u.issue(1'b0, 1'b1, OP_PRE, 2'h2, 14'h0400);
        late();
        chk({4'h0, bank_active}, 8'h0);
        m_u.issue(1'b1, 1'b0, OP_ACT, 2'h0, 14'h0);
        late();
        chk({6'h0, self_refresh, power_down}, 8'h1);
        m_u.issue(1'b1, 1'b1, OP_ACT, 2'h0, 14'h0);
        late();
        chk({6'h0, self_refresh, power_down}, 8'h0);
        m_u.issue(1'b0, 1'b0, OP_REF, 2'h0, 14'h0);
        late();
        chk({6'h0, self_refresh, power_down}, 8'h3);
        m_u.issue(1'b1, 1'b1, OP_ACT, 2'h0, 14'h0);
        late();
        chk({6'h0, self_refresh, power_down}, 8'h0);
        chk(8'(exp_q.size()), 8'h0);
        test_done();
    end
endmodule : dsc_ddr2_cmd_tb
